// >>> hdl/bcm_boot_mailbox.sv
// Boot configuration loader with flash probe, strap decode and host command mailbox.
// What this block does
// - Run boot mode selection after reset release.
// - Valid flash and records: apply flash settings.
// - Valid flash without records: auto-configuration, or host configuration with a grounded strap.
// - Identifier 0x00 or 0xFF means no flash.
// - Sample data-in strap during flash detection.
// - Grounded strap without a valid flash record: idle in host configuration.
// - No flash, strap high: sample general inputs.
// - Inputs pick standard, mirror and pedestal.
// - Reads use 0x03, 0x0B, status 0x05.
// - Write enable, program, erase opcodes defined.
// - Identifier read uses opcode 0x9F.
// - Command write with bit 15 rings doorbell.
// - Firmware clears doorbell, leaves result status.
`timescale 1ns/100ps
`include "bcm_defs.svh"
module bcm_boot_mailbox (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  output logic                           spi_sck,
  output logic                           spi_cs_n,
  output logic                           spi_mosi,
  input  wire logic                      spi_miso,
  input  wire logic                      fast_read_en,
  input  wire logic [2:0]                general_input,
  input  wire logic                      slave_address_select,
  input  wire logic                      twi_scl,
  input  wire logic                      twi_sda_in,
  output logic                           twi_sda_out,
  output logic                           twi_sda_oe,
  output logic                           boot_done,
  output bcm_pkg::bcm_mode_e             cfg_mode,
  output logic                           cfg_pal,
  output logic                           cfg_mirror,
  output logic                           cfg_pedestal,
  output logic                           fw_doorbell_irq,
  output logic                           fw_doorbell,
  output logic [15:0]                    fw_cmd,
  input  wire logic                      fw_done,
  input  wire logic [14:0]               fw_result,
  input  wire logic                      fw_pool_we,
  input  wire logic [`BCM_POOL_IDX_W-1:0] fw_pool_idx,
  input  wire logic [15:0]               fw_pool_wdata,
  output logic [15:0]                    fw_pool_rdata
);
  import bcm_pkg::*;

  // Pins from outside the clock domain: flash data in, general inputs, address select, two-wire pins.
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw, meta_q, sync_q;
  assign pin_raw = {spi_miso, general_input, slave_address_select, twi_scl, twi_sda_in};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      // No reset here, so the strap level is already through both stages when reset lets go.
      always_ff @(posedge core_clk) begin
        meta_q[g] <= pin_raw[g];
        sync_q[g] <= meta_q[g];
      end
    end
  endgenerate

  logic       miso_s, sel_s, scl_s, sda_s;
  logic [2:0] gi_s;
  assign {miso_s, gi_s, sel_s, scl_s, sda_s} = sync_q;

  // Boot sequencer and flash shift engine.
  bcm_boot_e  st_q, st_d;
  bcm_mode_e  mode_q, mode_d;
  logic [2:0] div_q, div_d;
  logic       sck_q, sck_d, strap_low_q, strap_low_d, done_q, done_d;
  logic [6:0] cnt_q, cnt_d, nbits_q, nbits_d;
  logic [39:0] tx_q, tx_d;
  logic [31:0] rx_q, rx_d;
  logic [2:0] cfg_q, cfg_d;
  logic       spi_busy, shift_end, id_none, rec_ok;

  assign spi_busy  = (st_q == BT_ID) || (st_q == BT_REC);
  assign shift_end = spi_busy && div_q == 3'(`BCM_SCK_HALF_CYC - 1) && sck_q && (cnt_q == nbits_q - 7'd1);
  assign id_none   = (rx_q[7:0] == `BCM_ID_NONE_LO) || (rx_q[7:0] == `BCM_ID_NONE_HI);
  assign rec_ok    = rx_q[31:16] == `BCM_CFG_MAGIC;

  always_comb begin
    st_d = st_q; mode_d = mode_q; div_d = div_q; sck_d = sck_q; strap_low_d = strap_low_q;
    done_d = done_q; cnt_d = cnt_q; nbits_d = nbits_q; tx_d = tx_q; rx_d = rx_q; cfg_d = cfg_q;
    if (spi_busy) begin
      if (div_q == 3'(`BCM_SCK_HALF_CYC - 1)) begin
        div_d = 3'h0;
        sck_d = ~sck_q;
        if (!sck_q) begin
          rx_d = {rx_q[30:0], miso_s};
        end else begin
          tx_d  = {tx_q[38:0], 1'b0};
          cnt_d = cnt_q + 7'd1;
        end
      end else begin
        div_d = div_q + 3'h1;
      end
    end
    case (st_q)
      BT_STRAP: begin
        // With the select still high the data-in pin shows only its strap.
        strap_low_d = ~miso_s;
        tx_d    = {`BCM_OP_READ_ID, 32'h0};
        nbits_d = 7'd16;
        cnt_d   = 7'd0;
        st_d    = BT_ID;
      end
      BT_ID: if (shift_end) st_d = BT_DECIDE;
      BT_DECIDE: begin
        cnt_d = 7'd0;
        if (!id_none) begin
          // Fast read needs one dummy byte, so the whole frame grows by eight clocks.
          tx_d    = fast_read_en ? {`BCM_OP_FAST_READ, `BCM_CFG_ADDR, 8'h00}
                                 : {`BCM_OP_READ, `BCM_CFG_ADDR, 8'h00};
          nbits_d = fast_read_en ? 7'd72 : 7'd64;
          st_d    = BT_REC;
        end else begin
          mode_d = strap_low_q ? BCM_MODE_HOST : BCM_MODE_AUTO;
          st_d   = BT_APPLY;
        end
      end
      BT_REC: if (shift_end) begin
        if (rec_ok) begin
          mode_d = BCM_MODE_FLASH;
          cfg_d  = rx_q[2:0];
        end else begin
          // A grounded strap keeps auto-configuration off even with a blank flash.
          mode_d = strap_low_q ? BCM_MODE_HOST : BCM_MODE_AUTO;
        end
        st_d = BT_APPLY;
      end
      BT_APPLY: begin
        if (mode_q == BCM_MODE_AUTO) cfg_d = gi_s;
        done_d = 1'b1;
        st_d   = BT_DONE;
      end
      BT_DONE: st_d = BT_DONE;
      default: st_d = BT_STRAP;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= BT_STRAP; mode_q <= BCM_MODE_NONE; div_q <= 3'h0; sck_q <= 1'b0; strap_low_q <= 1'b0;
      done_q <= 1'b0; cnt_q <= 7'd0; nbits_q <= 7'd0; tx_q <= 40'h0; rx_q <= 32'h0; cfg_q <= 3'h0;
    end else begin
      st_q <= st_d; mode_q <= mode_d; div_q <= div_d; sck_q <= sck_d; strap_low_q <= strap_low_d;
      done_q <= done_d; cnt_q <= cnt_d; nbits_q <= nbits_d; tx_q <= tx_d; rx_q <= rx_d; cfg_q <= cfg_d;
    end
  end

  assign spi_sck      = sck_q;
  assign spi_cs_n     = ~spi_busy;
  assign spi_mosi     = tx_q[39];
  assign boot_done    = done_q;
  assign cfg_mode     = mode_q;
  assign cfg_pal      = cfg_q[`BCM_CFG_PAL_BIT];
  assign cfg_mirror   = cfg_q[`BCM_CFG_MIRROR_BIT];
  assign cfg_pedestal = cfg_q[`BCM_CFG_PEDESTAL_BIT];

  // Host mailbox: command register and parameter pool behind the two-wire slave.
  logic        tw_we;
  logic [15:0] tw_waddr, tw_wdata, tw_raddr, tw_rdata;
  logic [15:0] cmd_q, cmd_d;
  logic        irq_q, irq_d, host_cmd_wr, host_pool_wr;
  logic [15:0] pool_q [`BCM_POOL_WORDS];
  logic [15:0] pool_d [`BCM_POOL_WORDS];
  localparam logic [15:0] POOL_BASE = `BCM_REG_POOL;

  bcm_twi_slave u_twi (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .scl_s      (scl_s),
    .sda_s      (sda_s),
    .addr_sel_s (sel_s),
    .rdata      (tw_rdata),
    .sda_oe     (twi_sda_oe),
    .we         (tw_we),
    .waddr      (tw_waddr),
    .wdata      (tw_wdata),
    .raddr      (tw_raddr)
  );

  assign host_cmd_wr  = tw_we && tw_waddr == `BCM_REG_CMD;
  assign host_pool_wr = tw_we && tw_waddr[15:`BCM_POOL_IDX_W] == POOL_BASE[15:`BCM_POOL_IDX_W];

  always_comb begin
    cmd_d  = cmd_q;
    irq_d  = 1'b0;
    pool_d = pool_q;
    if (fw_pool_we) pool_d[fw_pool_idx] = fw_pool_wdata;
    // The host write comes last so that a command landing with a completion is never lost.
    if (host_pool_wr) pool_d[tw_waddr[`BCM_POOL_IDX_W-1:0]] = tw_wdata;
    if (fw_done) cmd_d = {1'b0, fw_result};
    if (host_cmd_wr) begin
      cmd_d = tw_wdata;
      irq_d = tw_wdata[`BCM_CMD_BELL_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_q <= 16'h0000;
      irq_q <= 1'b0;
      for (int i = 0; i < `BCM_POOL_WORDS; i++) pool_q[i] <= 16'h0000;
    end else begin
      cmd_q  <= cmd_d;
      irq_q  <= irq_d;
      pool_q <= pool_d;
    end
  end

  // Reads of unmapped addresses return zero; the doorbell is bit 15 of the command word.
  always_comb begin
    if (tw_raddr == `BCM_REG_CMD) tw_rdata = cmd_q;
    else if (tw_raddr[15:`BCM_POOL_IDX_W] == POOL_BASE[15:`BCM_POOL_IDX_W])
      tw_rdata = pool_q[tw_raddr[`BCM_POOL_IDX_W-1:0]];
    else tw_rdata = 16'h0000;
  end

  assign twi_sda_out     = 1'b0;
  assign fw_doorbell_irq = irq_q;
  assign fw_doorbell     = cmd_q[`BCM_CMD_BELL_BIT];
  assign fw_cmd          = cmd_q;
  assign fw_pool_rdata   = pool_q[fw_pool_idx];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence probe_done_s;
    st_q == BT_ID && shift_end;
  endsequence
  sequence decide_s;
    st_q == BT_DECIDE;
  endsequence

  id_opcode_a: assert property (st_q == BT_STRAP |=> tx_q[39:32] == `BCM_OP_READ_ID && !spi_cs_n)
    else $error("identifier read did not start with its opcode");
  no_flash_a: assert property (probe_done_s ##1 decide_s ##0 id_none |=>
      st_q == BT_APPLY && mode_q == (strap_low_q ? BCM_MODE_HOST : BCM_MODE_AUTO))
    else $error("no-flash identifier not handled as absent flash");
  flash_read_a: assert property (decide_s ##0 !id_none |=>
      st_q == BT_REC && tx_q[39:32] == (fast_read_en ? `BCM_OP_FAST_READ : `BCM_OP_READ))
    else $error("valid flash not followed by record read");
  flash_mode_a: assert property (st_q == BT_REC && shift_end && rec_ok |=> mode_q == BCM_MODE_FLASH ##1 done_q)
    else $error("valid record did not select flash mode");
  blank_flash_a: assert property (st_q == BT_REC && shift_end && !rec_ok && !strap_low_q |=> mode_q == BCM_MODE_AUTO)
    else $error("blank flash did not fall back to auto mode");
  auto_map_a: assert property (st_q == BT_APPLY && mode_q == BCM_MODE_AUTO |=>
      {cfg_pal, cfg_mirror, cfg_pedestal} == $past(gi_s) && boot_done)
    else $error("auto mode settings differ from general inputs");
  boot_hold_a: assert property (boot_done |=> boot_done && $stable(cfg_mode) && spi_cs_n)
    else $error("boot result changed after completion");
  sck_idle_a: assert property (spi_cs_n |-> !spi_sck)
    else $error("flash clock active while deselected");
  doorbell_a: assert property (host_cmd_wr && tw_wdata[`BCM_CMD_BELL_BIT] |=> fw_doorbell_irq && fw_doorbell ##1 !fw_doorbell_irq)
    else $error("command write did not ring the doorbell");
  bell_clear_a: assert property (fw_done && !host_cmd_wr |=> !fw_doorbell && fw_cmd[14:0] == $past(fw_result))
    else $error("completion did not clear doorbell with result");
  set_wins_a: assert property (fw_done && host_cmd_wr |=> fw_cmd == $past(tw_wdata))
    else $error("new command lost against completion");
endmodule

// >>> hdl/bcm_defs.svh
// Constants for the boot configuration loader and host command mailbox.
`ifndef BCM_DEFS_SVH
`define BCM_DEFS_SVH

// Serial flash opcodes.
`define BCM_OP_READ       8'h03
`define BCM_OP_FAST_READ  8'h0b
`define BCM_OP_READ_STAT  8'h05
`define BCM_OP_WRITE_EN   8'h06
`define BCM_OP_PAGE_PROG  8'h02
`define BCM_OP_BLK_ERASE  8'hd8
`define BCM_OP_CHIP_ERASE 8'hc7
`define BCM_OP_WRITE_STAT 8'h01
`define BCM_OP_WRITE_DIS  8'h04
`define BCM_OP_READ_ID    8'h9f

// Identifier values that mean no flash is attached.
`define BCM_ID_NONE_LO 8'h00
`define BCM_ID_NONE_HI 8'hff

// Configuration record in flash: a marker word then a settings word.
`define BCM_CFG_ADDR  24'h000000
`define BCM_CFG_MAGIC 16'ha55a

// Settings bit positions, shared by the flash record and the general inputs.
`define BCM_CFG_PAL_BIT      2
`define BCM_CFG_MIRROR_BIT   1
`define BCM_CFG_PEDESTAL_BIT 0

// Mailbox register map and command layout.
`define BCM_REG_CMD       16'h0040
`define BCM_REG_POOL      16'hfc00
`define BCM_POOL_IDX_W    3
`define BCM_POOL_WORDS    8
`define BCM_CMD_BELL_BIT  15

// Two-wire write addresses for each level of the address select pin.
`define BCM_TWI_ADDR_LO 8'h90
`define BCM_TWI_ADDR_HI 8'hba

// Flash clock timing.
`define BCM_CLK_PERIOD_NS 5
`define BCM_SCK_HALF_NS   20
`define BCM_SCK_HALF_CYC  ((`BCM_SCK_HALF_NS + `BCM_CLK_PERIOD_NS - 1) / `BCM_CLK_PERIOD_NS)

`endif

// >>> hdl/bcm_pkg.sv
// Types shared by the boot configuration loader and host command mailbox.
package bcm_pkg;
  typedef enum logic [1:0] {BCM_MODE_NONE, BCM_MODE_FLASH, BCM_MODE_AUTO, BCM_MODE_HOST} bcm_mode_e;
  typedef enum logic [2:0] {BT_STRAP, BT_ID, BT_DECIDE, BT_REC, BT_APPLY, BT_DONE} bcm_boot_e;
  typedef enum logic [2:0] {TW_IDLE, TW_RX, TW_RXACK, TW_LOAD, TW_TX, TW_TXACK} bcm_twi_e;
endpackage

// >>> hdl/bcm_twi_slave.sv
// Two-wire register slave with 16-bit register address and 16-bit data.
`timescale 1ns/100ps
`include "bcm_defs.svh"
module bcm_twi_slave (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_s,
  input  wire logic        sda_s,
  input  wire logic        addr_sel_s,
  input  wire logic [15:0] rdata,
  output logic             sda_oe,
  output logic             we,
  output logic [15:0]      waddr,
  output logic [15:0]      wdata,
  output logic [15:0]      raddr
);
  import bcm_pkg::*;

  bcm_twi_e    st_q, st_d;
  logic        scl_q, sda_q;
  logic [3:0]  bit_q, bit_d;
  logic [2:0]  byte_q, byte_d;
  logic [7:0]  sh_q, sh_d, hi_q, hi_d, lo_q, lo_d;
  logic        rw_q, rw_d, half_q, half_d, oe_q, oe_d, we_q, we_d;
  logic [15:0] addr_q, addr_d, wa_q, wa_d, wd_q, wd_d;
  logic [7:0]  my_addr;
  logic        rise, fall, start, stop;

  assign my_addr = addr_sel_s ? `BCM_TWI_ADDR_HI : `BCM_TWI_ADDR_LO;
  assign rise    = scl_s & ~scl_q;
  assign fall    = ~scl_s & scl_q;
  assign start   = scl_s & scl_q & sda_q & ~sda_s;
  assign stop    = scl_s & scl_q & ~sda_q & sda_s;

  always_comb begin
    st_d = st_q; bit_d = bit_q; byte_d = byte_q; sh_d = sh_q; hi_d = hi_q; lo_d = lo_q;
    rw_d = rw_q; half_d = half_q; oe_d = oe_q; we_d = 1'b0; addr_d = addr_q; wa_d = wa_q; wd_d = wd_q;
    if (start) begin
      st_d = TW_RX; bit_d = 4'h0; byte_d = 3'h0; oe_d = 1'b0;
    end else if (stop) begin
      st_d = TW_IDLE; oe_d = 1'b0;
    end else begin
      case (st_q)
        TW_RX: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
          end else if (fall && bit_q == 4'h8) begin
            bit_d = 4'h0;
            st_d  = TW_RXACK;
            oe_d  = 1'b1;
            case (byte_q)
              3'h0: begin
                rw_d = sh_q[0];
                if (sh_q[7:1] != my_addr[7:1]) begin
                  st_d = TW_IDLE;
                  oe_d = 1'b0;
                end
              end
              3'h1: addr_d[15:8] = sh_q;
              3'h2: addr_d[7:0] = sh_q;
              3'h3: hi_d = sh_q;
              default: begin
                we_d   = 1'b1;
                wa_d   = addr_q;
                wd_d   = {hi_q, sh_q};
                addr_d = addr_q + 16'h0001;
              end
            endcase
            byte_d = (byte_q == 3'h4) ? 3'h3 : byte_q + 3'h1;
          end
        end
        TW_RXACK: if (fall) begin
          oe_d = 1'b0;
          st_d = rw_q ? TW_LOAD : TW_RX;
          half_d = 1'b0;
        end
        TW_LOAD: begin
          // The word is fetched one cycle after the address moves, long before the clock rises.
          sh_d  = rdata[15:8];
          lo_d  = rdata[7:0];
          oe_d  = ~rdata[15];
          bit_d = 4'h0;
          st_d  = TW_TX;
        end
        TW_TX: begin
          if (rise) begin
            bit_d = bit_q + 4'h1;
          end else if (fall) begin
            if (bit_q == 4'h8) begin
              oe_d = 1'b0;
              st_d = TW_TXACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        TW_TXACK: begin
          if (rise && sda_s) begin
            st_d = TW_IDLE;
          end else if (fall) begin
            bit_d = 4'h0;
            if (!half_q) begin
              sh_d = lo_q; oe_d = ~lo_q[7]; half_d = 1'b1; st_d = TW_TX;
            end else begin
              addr_d = addr_q + 16'h0001; half_d = 1'b0; st_d = TW_LOAD;
            end
          end
        end
        default: st_d = TW_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= TW_IDLE; scl_q <= 1'b1; sda_q <= 1'b1; bit_q <= 4'h0; byte_q <= 3'h0;
      sh_q <= 8'h00; hi_q <= 8'h00; lo_q <= 8'h00; rw_q <= 1'b0; half_q <= 1'b0;
      oe_q <= 1'b0; we_q <= 1'b0; addr_q <= 16'h0000; wa_q <= 16'h0000; wd_q <= 16'h0000;
    end else begin
      st_q <= st_d; scl_q <= scl_s; sda_q <= sda_s; bit_q <= bit_d; byte_q <= byte_d;
      sh_q <= sh_d; hi_q <= hi_d; lo_q <= lo_d; rw_q <= rw_d; half_q <= half_d;
      oe_q <= oe_d; we_q <= we_d; addr_q <= addr_d; wa_q <= wa_d; wd_q <= wd_d;
    end
  end

  assign sda_oe = oe_q;
  assign we     = we_q;
  assign waddr  = wa_q;
  assign wdata  = wd_q;
  assign raddr  = addr_q;
endmodule

// >>> tb/bcm_flash_model.sv
// Serial flash stand-in that answers the identifier probe and array reads.
`timescale 1ns/100ps
`include "bcm_defs.svh"
module bcm_flash_model (
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  input  wire logic        clr,
  input  wire logic        strap,
  input  wire logic [7:0]  id_byte,
  input  wire logic [31:0] record,
  output logic             spi_miso,
  output logic [7:0]       first_op,
  output logic [7:0]       last_op,
  output logic [3:0]       frames
);
  logic [31:0] rx_q;
  logic [31:0] word;
  logic        out_b = 1'b0;
  int          cnt = 0;
  int          start;
  // Deselected, the data line rests at the level of the board strap.
  assign spi_miso = spi_cs_n ? strap : out_b;
  // Reset may already be high at time zero, when no rising edge is seen.
  initial begin
    frames = 4'h0;
    first_op = 8'h00;
  end
  always @(posedge clr) begin
    frames = 4'h0;
    first_op = 8'h00;
  end
  always @(negedge spi_cs_n) begin
    cnt = 0;
    frames = frames + 4'h1;
  end
  always @(posedge spi_sck) begin
    if (!spi_cs_n) begin
      rx_q = {rx_q[30:0], spi_mosi};
      cnt = cnt + 1;
      if (cnt == 8) last_op = rx_q[7:0];
      if (cnt == 8 && frames == 4'h1) first_op = rx_q[7:0];
    end
  end
  // Outside the answer the line toggles every bit, so a stale level can never pass for data.
  always @(negedge spi_sck) begin
    if (!spi_cs_n) begin
      start = (last_op == `BCM_OP_READ_ID) ? 8 : (last_op == `BCM_OP_FAST_READ) ? 40 : 32;
      word = (last_op == `BCM_OP_READ_ID) ? {id_byte, 24'h0} : record;
      out_b = (cnt >= start && cnt < start + 32) ? word[31 - (cnt - start)] : ~out_b;
    end
  end
endmodule

// >>> tb/test_bcm_boot_mailbox.sv
// Self-checking bench for the boot loader and host command mailbox.
`timescale 1ns/100ps
`include "bcm_defs.svh"
module test_bcm_boot_mailbox;
  import bcm_pkg::*;
  logic        core_clk = 1'b0, sys_rst = 1'b1, scl = 1'b1, sda_m = 1'b1, sel = 1'b0, strap = 1'b1;
  logic        fast_read_en = 1'b0, fw_done = 1'b0, fw_pool_we = 1'b0, done_q = 1'b0;
  logic        spi_sck, spi_cs_n, spi_mosi, spi_miso, sda_w, sda_out, sda_oe, boot_done;
  logic        cfg_pal, cfg_mirror, cfg_pedestal, fw_doorbell_irq, fw_doorbell;
  logic [2:0]  gi = 3'h0;
  logic [`BCM_POOL_IDX_W-1:0] fw_pool_idx = '0;
  logic [7:0]  id_byte = 8'h00, first_op, last_op;
  logic [3:0]  frames;
  logic [14:0] fw_result = 15'h0;
  logic [15:0] fw_cmd, fw_pool_wdata = 16'h0, fw_pool_rdata, pool [8];
  logic [31:0] record = 32'h0, exp_boot[$], exp_cmd[$], exp_rd[$], got_rd[$];
  bcm_mode_e   cfg_mode;
  int          fails = 0, checks = 0, seed;
  assign sda_w = sda_m & ~(sda_oe & ~sda_out);
  bcm_boot_mailbox dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .fast_read_en(fast_read_en), .general_input(gi),
    .slave_address_select(sel), .twi_scl(scl), .twi_sda_in(sda_w), .twi_sda_out(sda_out),
    .twi_sda_oe(sda_oe), .boot_done(boot_done), .cfg_mode(cfg_mode), .cfg_pal(cfg_pal),
    .cfg_mirror(cfg_mirror), .cfg_pedestal(cfg_pedestal), .fw_doorbell_irq(fw_doorbell_irq),
    .fw_doorbell(fw_doorbell), .fw_cmd(fw_cmd), .fw_done(fw_done), .fw_result(fw_result),
    .fw_pool_we(fw_pool_we), .fw_pool_idx(fw_pool_idx), .fw_pool_wdata(fw_pool_wdata),
    .fw_pool_rdata(fw_pool_rdata));
  bcm_flash_model flash_u (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .clr(sys_rst),
    .strap(strap), .id_byte(id_byte), .record(record), .spi_miso(spi_miso), .first_op(first_op),
    .last_op(last_op), .frames(frames));
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_val({31'h0, got}, {31'h0, exp}, what);
  endtask
  task automatic summarize;
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  function automatic logic [7:0] dw();
    return sel ? `BCM_TWI_ADDR_HI : `BCM_TWI_ADDR_LO;
  endfunction
  // One bus bit of about 65 ns; the line is sampled in the middle of the high phase.
  task automatic clk_bit(input logic b, output logic s);
    sda_m <= b;
    cyc(3);
    scl <= 1'b1;
    cyc(3);
    s = sda_w;
    cyc(3);
    scl <= 1'b0;
    cyc(4);
  endtask
  task automatic tw_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
    clk_bit(ack_in, ack);
  endtask
  task automatic tw_edge(input logic first, input logic second);
    sda_m <= first;
    cyc(3);
    scl <= 1'b1;
    cyc(3);
    sda_m <= second;
    cyc(3);
    scl <= second;
    cyc(3);
  endtask
  task automatic reg_wr(input logic [7:0] dv, input logic [15:0] a, input logic [15:0] d);
    logic [39:0] seq;
    logic [7:0]  rx;
    logic        ack;
    seq = {dv, a, d};
    tw_edge(1'b1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      tw_byte(seq[39 - 8 * i -: 8], 1'b1, rx, ack);
      chk_bit(ack, dv != dw(), "write ack");
      if (ack) break;
    end
    tw_edge(1'b0, 1'b1);
  endtask
  task automatic reg_rd(input logic [15:0] a, input logic [31:0] exp);
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ack;
    tw_edge(1'b1, 1'b0);
    tw_byte(dw(), 1'b1, hi, ack);
    tw_byte(a[15:8], 1'b1, hi, ack);
    tw_byte(a[7:0], 1'b1, hi, ack);
    tw_edge(1'b1, 1'b0);
    tw_byte(dw() | 8'h01, 1'b1, hi, ack);
    chk_bit(ack, 1'b0, "read address ack");
    tw_byte(8'hff, 1'b0, hi, ack);
    tw_byte(8'hff, 1'b1, lo, ack);
    tw_edge(1'b0, 1'b1);
    exp_rd.push_back(exp);
    got_rd.push_back({16'h0, hi, lo});
  endtask
  task automatic boot(input logic [7:0] id, input logic [31:0] rec, input logic st, input logic fr);
    logic nof;
    logic ok;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    id_byte <= id;
    record <= rec;
    strap <= st;
    fast_read_en <= fr;
    gi <= 3'($urandom);
    cyc(4);
    nof = (id == `BCM_ID_NONE_LO) || (id == `BCM_ID_NONE_HI);
    ok = !nof && rec[31:16] == `BCM_CFG_MAGIC;
    exp_boot.push_back({27'h0, ok ? BCM_MODE_FLASH : st ? BCM_MODE_AUTO : BCM_MODE_HOST,
                        ok ? rec[2:0] : st ? gi : 3'h0});
    sys_rst <= 1'b0;
    for (int i = 0; i < 2000 && boot_done !== 1'b1; i++) @(posedge core_clk);
    cyc(2);
    chk_bit(boot_done, 1'b1, "boot finished");
    chk_val(32'(frames), nof ? 32'h1 : 32'h2, "flash frames");
    chk_val(32'(first_op), 32'(`BCM_OP_READ_ID), "probe opcode");
    if (!nof) chk_val(32'(last_op), fr ? 32'(`BCM_OP_FAST_READ) : 32'(`BCM_OP_READ), "read opcode");
  endtask
  always @(posedge core_clk) begin
    done_q <= boot_done;
    if (boot_done === 1'b1 && done_q !== 1'b1) begin
      chk_val({27'h0, cfg_mode, cfg_pal, cfg_mirror, cfg_pedestal}, exp_boot.pop_front(), "boot result");
    end
    if (!sys_rst && fw_doorbell_irq !== 1'b0) begin
      chk_val({16'h0, fw_cmd}, exp_cmd.size() > 0 ? exp_cmd.pop_front() : 32'hdead, "doorbell");
    end
    while (got_rd.size() > 0) chk_val(got_rd.pop_front(), exp_rd.pop_front(), "read data");
  end
  initial begin
    #400000;
    fails++;
    summarize();
  end
  initial begin
    seed = $urandom(32'hf2a3a455);
    boot(8'h00, {`BCM_CFG_MAGIC, 16'h0007}, 1'b0, 1'b0);
    boot(8'h01, {`BCM_CFG_MAGIC, 16'h0005}, 1'b1, 1'b0);
    boot(8'hfe, {`BCM_CFG_MAGIC, 16'h0002}, 1'b0, 1'b1);
    boot(8'h3c, 32'h5aa50007, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) boot(8'hff, $urandom, 1'b1, 1'b0);
    boot(8'h3c, 32'h5aa50007, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      pool[i] = 16'($urandom);
      reg_wr(dw(), `BCM_REG_POOL + 16'(i), pool[i]);
      fw_pool_idx <= 3'(i);
      cyc(2);
      chk_val({16'h0, fw_pool_rdata}, {16'h0, pool[i]}, "pool word");
    end
    pool[5] = 16'($urandom);
    fw_pool_idx <= 3'h5;
    fw_pool_wdata <= pool[5];
    fw_pool_we <= 1'b1;
    cyc(1);
    fw_pool_we <= 1'b0;
    exp_cmd.push_back(32'h8801);
    reg_wr(dw(), `BCM_REG_CMD, 16'h8801);
    reg_rd(`BCM_REG_CMD, 32'h8801);
    chk_bit(fw_doorbell, 1'b1, "doorbell set");
    fw_result <= 15'($urandom);
    fw_done <= 1'b1;
    cyc(1);
    fw_done <= 1'b0;
    cyc(2);
    chk_bit(fw_doorbell, 1'b0, "doorbell clear");
    reg_rd(`BCM_REG_CMD, {17'h0, fw_result});
    for (int i = 0; i < 8; i++) reg_rd(`BCM_REG_POOL + 16'(i), {16'h0, pool[i]});
    reg_wr(dw(), 16'h0041, 16'hbeef);
    reg_rd(16'h0041, 32'h0);
    reg_wr(dw(), `BCM_REG_CMD, 16'h0801);
    chk_bit(fw_doorbell, 1'b0, "no doorbell without bit 15");
    sel <= 1'b1;
    cyc(4);
    reg_wr(`BCM_TWI_ADDR_LO, `BCM_REG_POOL, 16'h1234);
    reg_rd(`BCM_REG_POOL, {16'h0, pool[0]});
    cyc(4);
    summarize();
  end
endmodule
